// *** design/ssh_pkg.sv ***
// Constants, command codes and field layout for the status summary hierarchy
package ssh_pkg;

  localparam int DW = 16;
  localparam int SW = 8;

  // Command codes on the remote command port
  typedef enum logic [4:0] {
    SSH_RD_TOP       = 5'h00,
    SSH_RD_POLL_MASK = 5'h01,
    SSH_WR_POLL_MASK = 5'h02,
    SSH_RD_POLL_FLAG = 5'h03,
    SSH_RD_EVT_STAT  = 5'h04,
    SSH_RD_EVT_EN    = 5'h05,
    SSH_WR_EVT_EN    = 5'h06,
    SSH_RD_OPER_COND = 5'h07,
    SSH_RD_OPER_EVT  = 5'h08,
    SSH_RD_OPER_EN   = 5'h09,
    SSH_WR_OPER_EN   = 5'h0A
  } ssh_cmd_t;

  // Three structured registers, four codes each from 0x0C: cond, event, enable rd, enable wr
  localparam logic [2:0] SCPI_GROUP_BASE = 3'h3;
  localparam int SCPI_NUM = 3;
  localparam int SCPI_QUES = 0;
  localparam int SCPI_LIM1 = 1;
  localparam int SCPI_LIM2 = 2;
  typedef enum logic [1:0] {
    SSH_OP_COND   = 2'h0,
    SSH_OP_EVENT  = 2'h1,
    SSH_OP_EN_RD  = 2'h2,
    SSH_OP_EN_WR  = 2'h3
  } ssh_op_t;

  // Implemented bits per structured register; the rest read zero
  localparam logic [SCPI_NUM-1:0][DW-1:0] SCPI_VALID = {16'h0006, 16'h7FFF, 16'h0600};

  // Questionable-data field positions
  localparam int QUES_STATUS_A_BIT = 9;
  localparam int QUES_LIMIT_BIT = 10;
  // First-level limit: bit 0 summary, bits 1..14 traces 1..14
  localparam int LIM1_SUMMARY_BIT = 0;
  localparam int LIM1_TRACES = 14;
  // Second-level limit: bits 1,2 traces 15,16
  localparam int LIM2_FIRST_BIT = 1;
  localparam int TRACES = 16;

  // Event status fields
  localparam int EVS_DONE_BIT = 0;
  localparam int EVS_QUERY_BIT = 2;
  localparam int EVS_DEVICE_BIT = 3;
  localparam int EVS_EXEC_BIT = 4;
  localparam int EVS_COMMAND_BIT = 5;
  localparam int EVS_POWER_BIT = 7;
  localparam logic [SW-1:0] EVS_VALID = 8'hBD;
  localparam logic [SW-1:0] EVS_RESET = 8'h80;

  // Status byte fields
  localparam int TSB_ERRQ_BIT = 2;
  localparam int TSB_QUES_BIT = 3;
  localparam int TSB_MAV_BIT = 4;
  localparam int TSB_EVT_SUM_BIT = 5;
  localparam int TSB_MSS_BIT = 6;
  localparam int TSB_OPER_BIT = 7;

  // Error numbers queued per class, two's complement
  localparam logic [DW-1:0] ERR_DEVICE = 16'hFED4;
  localparam logic [DW-1:0] ERR_EXEC = 16'hFF38;
  localparam logic [DW-1:0] ERR_COMMAND = 16'hFF9C;

  localparam logic [SW-1:0] POLL_MASK_RESET = 8'h00;
  localparam logic [SW-1:0] EVT_EN_RESET = 8'h00;
  localparam logic [DW-1:0] EN_RESET = 16'h0000;

endpackage

// *** design/ssh_reg_if.sv ***
// Carrier between the top and its event/enable register modules
`timescale 1ns/1ps
interface ssh_reg_if;
  logic [15:0] cond;
  logic evt_rd;
  logic en_wr;
  logic [15:0] en_data;
  logic [15:0] event_bits;
  logic [15:0] enable_bits;
  logic summary;

  modport reg_side (
    input cond,
    input evt_rd,
    input en_wr,
    input en_data,
    output event_bits,
    output enable_bits,
    output summary
  );
  modport user_side (
    output cond,
    output evt_rd,
    output en_wr,
    output en_data,
    input event_bits,
    input enable_bits,
    input summary
  );
endinterface

// *** design/ssh_scpi_reg.sv ***
// Condition/event/enable register with positive transition latching
`timescale 1ns/1ps
module ssh_scpi_reg #(
  parameter logic [15:0] VALID = 16'hFFFF
) (
  input wire logic clock,
  input wire logic rst_b,
  ssh_reg_if.reg_side r
);
  import ssh_pkg::*;

  logic [DW-1:0] cond_last;
  logic [DW-1:0] rise;

  assign rise = r.cond & ~cond_last & VALID;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cond_last <= EN_RESET;
    end else begin
      cond_last <= r.cond;
    end
  end

  // Rise latched even in the cycle of a destructive read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r.event_bits <= EN_RESET;
    end else begin
      r.event_bits <= (r.evt_rd ? EN_RESET : r.event_bits) | rise;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r.enable_bits <= EN_RESET;
    end else if (r.en_wr) begin
      r.enable_bits <= r.en_data & VALID;
    end
  end

  assign r.summary = |(r.event_bits & r.enable_bits);
endmodule

// *** design/ssh_event_status.sv ***
// Event status register with its enable mask
`timescale 1ns/1ps
module ssh_event_status (
  input wire logic clock,
  input wire logic rst_b,
  ssh_reg_if.reg_side r
);
  import ssh_pkg::*;

  // Power-on bit comes up set straight out of reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r.event_bits <= {8'h00, EVS_RESET};
    end else begin
      r.event_bits <= (r.evt_rd ? EN_RESET : r.event_bits) |
        {8'h00, r.cond[SW-1:0] & EVS_VALID};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r.enable_bits <= EN_RESET;
    end else if (r.en_wr) begin
      r.enable_bits <= {8'h00, r.en_data[SW-1:0]};
    end
  end

  assign r.summary = |(r.event_bits & r.enable_bits);
endmodule

// *** design/ssh_status_top.sv ***
// Status summary hierarchy: status byte, poll flag, event status and limit registers
//
// Functional notes
// - Poll flag is OR of status byte AND mask
// - Poll mask read/write, poll flag readable
// - Event status read returns value then clears
// - Enabled event status rise sets event summary
// - Bit 0 on operation-complete after prior commands
// - Bit 2 on unprompted read or unfetched response
// - Device error sets bit 3, queues -300
// - Execution error sets bit 4, queues -200
// - Command error sets bit 5, queues -100
// - Bit 7 set at power up
// - Operation register present, never sets bits
// - Questionable condition and event read separately
// - Questionable bit 9 from status_a summary
// - Questionable bit 10 from first limit summary
// - First limit bit 0 summarises second limit
// - First limit bits 1-14 flag traces 1-14
// - Second limit bits 1,2 flag traces 15,16
// - Summary is OR of event AND enable
// - Status byte bit 5 is event summary
`timescale 1ns/1ps
module ssh_status_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic [ssh_pkg::DW-1:0] cmd_data,
  input wire logic op_complete_cmd,
  input wire logic cmds_all_done,
  input wire logic query_read_empty,
  input wire logic query_unfetched,
  input wire logic dev_error,
  input wire logic exec_error,
  input wire logic cmd_error,
  input wire logic err_queue_nonempty,
  input wire logic msg_available,
  input wire logic [ssh_pkg::SW-1:0] service_request_mask,
  input wire logic status_a_summary,
  input wire logic [ssh_pkg::TRACES-1:0] trace_fail,
  output logic rsp_valid,
  output logic [ssh_pkg::DW-1:0] rsp_data,
  output logic [ssh_pkg::SW-1:0] top_status_byte,
  output logic poll_summary_flag,
  output logic err_push,
  output logic [ssh_pkg::DW-1:0] err_code
);
  import ssh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [SW-1:0] poll_enable_mask;
  logic op_complete_pending;
  logic op_complete_fire;
  logic [SW-1:0] evt_set;
  logic [SW-1:0] next_top_status;
  logic next_poll_flag;
  logic [DW-1:0] next_rsp;
  logic [SCPI_NUM-1:0][DW-1:0] scpi_rd;
  logic [SCPI_NUM-1:0] scpi_hit;
  logic [SCPI_NUM-1:0] scpi_sum;
  logic [SCPI_NUM-1:0][DW-1:0] scpi_cond;
  logic [1:0] scpi_op;
  logic evt_rd_cmd;

  ssh_reg_if evs_if ();
  ssh_reg_if scpi_if [SCPI_NUM] ();

  assign scpi_op = cmd_code[1:0];
  assign evt_rd_cmd = cmd_valid && (cmd_code == SSH_RD_EVT_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // Operation-complete tracking

  // Held until the command pipeline drains so the bit never runs ahead of work
  assign op_complete_fire = (op_complete_pending || op_complete_cmd) && cmds_all_done;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      op_complete_pending <= 1'b0;
    end else begin
      op_complete_pending <= (op_complete_pending || op_complete_cmd) && !cmds_all_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status register

  always_comb begin
    evt_set = 8'h00;
    evt_set[EVS_DONE_BIT] = op_complete_fire;
    evt_set[EVS_QUERY_BIT] = query_read_empty || query_unfetched;
    evt_set[EVS_DEVICE_BIT] = dev_error;
    evt_set[EVS_EXEC_BIT] = exec_error;
    evt_set[EVS_COMMAND_BIT] = cmd_error;
  end

  assign evs_if.cond = {8'h00, evt_set};
  assign evs_if.evt_rd = evt_rd_cmd;
  assign evs_if.en_wr = cmd_valid && (cmd_code == SSH_WR_EVT_EN);
  assign evs_if.en_data = cmd_data;

  ssh_event_status u_evs (
    .clock(clock),
    .rst_b(rst_b),
    .r(evs_if.reg_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Error queue entries

  // One entry per cycle; if classes coincide command beats execution and execution beats device
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_push <= 1'b0;
      err_code <= EN_RESET;
    end else begin
      err_push <= cmd_error || exec_error || dev_error;
      if (cmd_error) begin
        err_code <= ERR_COMMAND;
      end else if (exec_error) begin
        err_code <= ERR_EXEC;
      end else if (dev_error) begin
        err_code <= ERR_DEVICE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Questionable and limit registers

  always_comb begin
    scpi_cond = '0;
    scpi_cond[SCPI_QUES][QUES_STATUS_A_BIT] = status_a_summary;
    scpi_cond[SCPI_QUES][QUES_LIMIT_BIT] = scpi_sum[SCPI_LIM1];
    scpi_cond[SCPI_LIM1][LIM1_SUMMARY_BIT] = scpi_sum[SCPI_LIM2];
    scpi_cond[SCPI_LIM1][LIM1_TRACES:1] = trace_fail[LIM1_TRACES-1:0];
    scpi_cond[SCPI_LIM2][LIM2_FIRST_BIT+1:LIM2_FIRST_BIT] =
      trace_fail[TRACES-1:LIM1_TRACES];
  end

  generate
    for (genvar i = 0; i < SCPI_NUM; i++) begin : g_scpi
      assign scpi_hit[i] = cmd_valid && (cmd_code[4:2] == SCPI_GROUP_BASE + 3'(i));
      assign scpi_if[i].cond = scpi_cond[i];
      assign scpi_if[i].evt_rd = scpi_hit[i] && (scpi_op == SSH_OP_EVENT);
      assign scpi_if[i].en_wr = scpi_hit[i] && (scpi_op == SSH_OP_EN_WR);
      assign scpi_if[i].en_data = cmd_data;
      assign scpi_sum[i] = scpi_if[i].summary;

      always_comb begin
        case (scpi_op)
          SSH_OP_COND: scpi_rd[i] = scpi_cond[i] & SCPI_VALID[i];
          SSH_OP_EVENT: scpi_rd[i] = scpi_if[i].event_bits;
          SSH_OP_EN_RD: scpi_rd[i] = scpi_if[i].enable_bits;
          default: scpi_rd[i] = EN_RESET;
        endcase
      end

      ssh_scpi_reg #(
        .VALID(SCPI_VALID[i])
      ) u_reg (
        .clock(clock),
        .rst_b(rst_b),
        .r(scpi_if[i].reg_side)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and poll flag

  always_comb begin
    next_top_status = 8'h00;
    next_top_status[TSB_ERRQ_BIT] = err_queue_nonempty;
    next_top_status[TSB_QUES_BIT] = scpi_sum[SCPI_QUES];
    next_top_status[TSB_MAV_BIT] = msg_available;
    next_top_status[TSB_EVT_SUM_BIT] = evs_if.summary;
    // Operation register is never set, so its summary stays low
    next_top_status[TSB_OPER_BIT] = 1'b0;
    // Mask bit 6 ignored here; it would feed back on itself
    next_top_status[TSB_MSS_BIT] =
      |(next_top_status & service_request_mask & ~(8'h01 << TSB_MSS_BIT));
  end

  // Unlike the service request, bit 6 takes part here
  assign next_poll_flag = |(next_top_status & poll_enable_mask);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      top_status_byte <= 8'h00;
      poll_summary_flag <= 1'b0;
    end else begin
      top_status_byte <= next_top_status;
      poll_summary_flag <= next_poll_flag;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      poll_enable_mask <= POLL_MASK_RESET;
    end else if (cmd_valid && (cmd_code == SSH_WR_POLL_MASK)) begin
      poll_enable_mask <= cmd_data[SW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command answers

  always_comb begin
    next_rsp = EN_RESET;
    case (cmd_code)
      SSH_RD_TOP: next_rsp = {8'h00, next_top_status};
      SSH_RD_POLL_MASK: next_rsp = {8'h00, poll_enable_mask};
      SSH_RD_POLL_FLAG: next_rsp = {15'h0000, next_poll_flag};
      SSH_RD_EVT_STAT: next_rsp = evs_if.event_bits;
      SSH_RD_EVT_EN: next_rsp = evs_if.enable_bits;
      // Operation register answers all zeros and keeps no enable
      SSH_RD_OPER_COND: next_rsp = EN_RESET;
      SSH_RD_OPER_EVT: next_rsp = EN_RESET;
      SSH_RD_OPER_EN: next_rsp = EN_RESET;
      default: begin
        for (int k = 0; k < SCPI_NUM; k++) begin
          if (scpi_hit[k]) begin
            next_rsp = scpi_rd[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data <= EN_RESET;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_data <= cmd_valid ? next_rsp : EN_RESET;
    end
  end
endmodule

// *** tb/ssh_status_properties.sv ***
// Port checks for the status summary hierarchy
`timescale 1ns/1ps
module ssh_status_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic dev_error,
  input wire logic exec_error,
  input wire logic cmd_error,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] top_status_byte,
  input wire logic err_push,
  input wire logic [15:0] err_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rsp; cmd_valid |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_quiet; !cmd_valid |=> !rsp_valid && rsp_data == 16'h0000; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_wr; cmd_valid && cmd_code == 5'h02 |=> rsp_data == 16'h0000; endproperty
  a_wr: assert property (p_wr) else $error("write answered data");
  property p_oper; cmd_valid && cmd_code inside {[5'h07:5'h0A]} |=> rsp_data == 16'h0000;
  endproperty
  a_oper: assert property (p_oper) else $error("operation reg not zero");
  property p_top7; top_status_byte[7] == 1'b0; endproperty
  a_top7: assert property (p_top7) else $error("operation summary set");
  property p_evs; cmd_valid && cmd_code == 5'h04 |=> (rsp_data & 16'hFF42) == 16'h0000;
  endproperty
  a_evs: assert property (p_evs) else $error("reserved event bit read");
  property p_cmd; cmd_error |=> err_push && err_code == 16'hFF9C; endproperty
  a_cmd: assert property (p_cmd) else $error("command error entry");
  property p_exe; exec_error && !cmd_error |=> err_push && err_code == 16'hFF38; endproperty
  a_exe: assert property (p_exe) else $error("execution error entry");
  property p_dev; dev_error && !exec_error && !cmd_error |=> err_push && err_code == 16'hFED4;
  endproperty
  a_dev: assert property (p_dev) else $error("device error entry");
  property p_nop; !(dev_error || exec_error || cmd_error) |=> !err_push; endproperty
  a_nop: assert property (p_nop) else $error("spurious error entry");
  c_err: cover property (cmd_error ##1 err_push);
  c_evs: cover property (cmd_valid && cmd_code == 5'h04);
  c_que: cover property (cmd_valid && cmd_code == 5'h0C);
endmodule

// *** tb/ssh_remote_ctl.sv ***
// Remote controller model issuing status commands
`timescale 1ns/1ps
module ssh_remote_ctl (
  input wire logic clock,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output logic [4:0] cmd_code,
  output logic [15:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 5'h00;
    cmd_data = 16'h0000;
  end
  // Answer taken at the edge after the command edge
  task automatic xfer(input logic [4:0] c, input logic [15:0] w, output logic [15:0] r);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = w;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    // Inverted so stale data is never taken for a write
    cmd_data = ~w;
    r = rsp_valid ? rsp_data : 16'hXXXX;
  endtask
endmodule

// *** tb/test_status_summary_hierarchy.sv ***
// Self-checking bench for the status summary hierarchy
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_status_summary_hierarchy;
  logic clock = 1'b0, rst_b = 1'b0, cmd_valid, op_complete_cmd = 1'b0, cmds_all_done = 1'b1;
  logic query_read_empty = 1'b0, query_unfetched = 1'b0, dev_error = 1'b0;
  logic exec_error = 1'b0, cmd_error = 1'b0, err_queue_nonempty = 1'b0;
  logic msg_available = 1'b0, status_a_summary = 1'b0, rsp_valid, poll_summary_flag;
  logic err_push;
  logic [4:0] cmd_code;
  logic [7:0] service_request_mask = 8'h00, top_status_byte;
  logic [15:0] cmd_data, trace_fail = 16'h0000, rsp_data, err_code, d;
  int fails = 0, tests_run = 0;
  always #50 clock = ~clock;
  ssh_remote_ctl ctl (.clock(clock), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));
  ssh_status_top uut (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .op_complete_cmd(op_complete_cmd),
    .cmds_all_done(cmds_all_done), .query_read_empty(query_read_empty),
    .query_unfetched(query_unfetched), .dev_error(dev_error), .exec_error(exec_error),
    .cmd_error(cmd_error), .err_queue_nonempty(err_queue_nonempty),
    .msg_available(msg_available), .service_request_mask(service_request_mask),
    .status_a_summary(status_a_summary), .trace_fail(trace_fail),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .top_status_byte(top_status_byte),
    .poll_summary_flag(poll_summary_flag), .err_push(err_push), .err_code(err_code));
  task automatic rd(input logic [4:0] c);
    ctl.xfer(c, 16'h0000, d);
  endtask
  task automatic wr(input logic [4:0] c, input logic [15:0] w);
    ctl.xfer(c, w, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_reset;
    rd(5'h04); `CHK(d, 16'h0080)
    rd(5'h04); `CHK(d, 16'h0000)
    rd(5'h08); `CHK(d, 16'h0000)
  endtask
  task automatic t_poll;
    // Only bit 6 enabled: flag must come from the request summary
    wr(5'h02, 16'h0040); rd(5'h01); `CHK(d, 16'h0040)
    service_request_mask = 8'h10;
    msg_available = 1'b1;
    wt(3); `CHK(top_status_byte, 8'h50)
    `CHK(poll_summary_flag, 1'b1)
    rd(5'h00); `CHK(d, 16'h0050)
    rd(5'h03); `CHK(d, 16'h0001)
    msg_available = 1'b0;
    wt(3); `CHK(poll_summary_flag, 1'b0)
  endtask
  task automatic t_events;
    logic [15:0] codes [3] = '{16'hFED4, 16'hFF38, 16'hFF9C};
    for (int i = 0; i < 3; i++) begin
      wt(1); {cmd_error, exec_error, dev_error} = 3'b001 << i;
      wt(1); {cmd_error, exec_error, dev_error} = 3'b000;
      `CHK(err_code, codes[i])
      rd(5'h04); `CHK(d, 16'h0008 << i)
    end
    wr(5'h06, 16'h0020);
    rd(5'h05); `CHK(d, 16'h0020)
    wt(1); cmd_error = 1'b1;
    wt(1); cmd_error = 1'b0;
    wt(2); `CHK(top_status_byte[5], 1'b1)
    rd(5'h04); wt(3); `CHK(top_status_byte[5], 1'b0)
    wt(1); query_read_empty = 1'b1;
    wt(1); query_read_empty = 1'b0;
    rd(5'h04); `CHK(d, 16'h0004)
    wt(1); query_unfetched = 1'b1;
    wt(1); query_unfetched = 1'b0;
    rd(5'h04); `CHK(d, 16'h0004)
    cmds_all_done = 1'b0;
    wt(1); op_complete_cmd = 1'b1;
    wt(1); op_complete_cmd = 1'b0;
    wt(3); rd(5'h04); `CHK(d, 16'h0000)
    cmds_all_done = 1'b1;
    wt(3); rd(5'h04); `CHK(d, 16'h0001)
  endtask
  task automatic t_limits;
    wr(5'h17, 16'hFFFF); rd(5'h16); `CHK(d, 16'h0006)
    wr(5'h13, 16'h0001);
    wr(5'h0F, 16'h0400);
    trace_fail = 16'h8000;
    wt(5); rd(5'h14); `CHK(d, 16'h0004)
    rd(5'h10); `CHK(d, 16'h0001)
    rd(5'h15); `CHK(d, 16'h0004)
    rd(5'h15); `CHK(d, 16'h0000)
    // First-level event bit 0 stays latched and keeps the parent summary up
    rd(5'h0C); `CHK(d, 16'h0400)
    `CHK(top_status_byte[3], 1'b1)
    trace_fail = 16'h8001;
    status_a_summary = 1'b1;
    // Second-level events were read, so bit 0 of the condition is low now
    wt(5); rd(5'h10); `CHK(d, 16'h0002)
    rd(5'h0C); `CHK(d, 16'h0600)
    rd(5'h0D); `CHK(d, 16'h0600)
    rd(5'h11); `CHK(d, 16'h0003)
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    wt(10); rst_b = 1'b1;
    t_reset();
    t_poll();
    t_events();
    t_limits();
    final_report();
  end
  initial begin
    #300000;
    fails++;
    final_report();
  end
endmodule
bind ssh_status_top ssh_status_properties chk (.clock(clock), .rst_b(rst_b),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .dev_error(dev_error),
  .exec_error(exec_error), .cmd_error(cmd_error), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .top_status_byte(top_status_byte), .err_push(err_push),
  .err_code(err_code));
